/* File: rtl/ssg_pkg.sv */
// constants and types for the spindle servo gain control block
// What this block does
// - coefficient gains apply only with digital spindle
// - rough gain from speed field plus rough bit
// - phase and speed gains: -6, 0, +6 dB
// - overall loop gain: 0, +6, +12 dB
// - digital spindle off: rough bit picks -12/0 dB
// - pin field drives both comparator pins alike
// - second pin floats unless its enable set
// - rough bit acts with digital spindle on or off
// - pwm select: both error outputs are pwm
// - pwm clear: phase output ternary, wide modes allowed
// - bottom hold every 32 or 16 frames
// - peak hold every 4 or 2 frames
// - target speed is (256 - code) / 32
// - double speed select doubles every target speed
// - auto mode: rough while pll is unlocked, phase once locked
package ssg_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_COEF = 8'h04;
    localparam logic [7:0] ADDR_CLVC = 8'h08;
    localparam logic [7:0] ADDR_CFG = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_VEL = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------
    // command word layout
    // ----------------------------------------
    localparam int OP_LSB = 24;
    localparam logic [3:0] OP_COEF = 4'hC;
    localparam logic [3:0] OP_CLV = 4'hD;
    localparam int COEF_LSB = 16;
    localparam int CLV_LSB = 12;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int COEF_PHASE = 6;
    localparam int COEF_SPEED = 4;
    localparam int COEF_OVERALL = 2;
    localparam int COEF_PIN = 0;
    localparam int CLV_PWM = 11;
    localparam int CLV_TB = 10;
    localparam int CLV_TP = 9;
    localparam int CLV_ROUGH = 8;
    localparam int CLV_VEL = 0;
    localparam int CFG_DIGITAL_SPINDLE_ENABLE = 0;
    localparam int CFG_SECOND = 1;
    localparam int CFG_DOUBLE_SPEED_SELECT = 2;
    localparam int CFG_MODE = 3;
    localparam logic [7:0] COEF_RST = 8'h50;
    localparam logic [11:0] CLV_RST = 12'h0E0;
    localparam logic [4:0] CFG_RST = 5'h00;
    // ----------------------------------------
    // gains in dB, hold divisors, velocity
    // ----------------------------------------
    localparam logic signed [5:0] DB_M12 = 6'sh34;
    localparam logic signed [5:0] DB_M6 = 6'sh3A;
    localparam logic signed [5:0] DB_0 = 6'sh00;
    localparam logic signed [5:0] DB_P6 = 6'sh06;
    localparam logic signed [5:0] DB_P12 = 6'sh0C;
    localparam int BOTTOM_SLOW_DIV = 32;
    localparam int BOTTOM_FAST_DIV = 16;
    localparam int PEAK_SLOW_DIV = 4;
    localparam int PEAK_FAST_DIV = 2;
    localparam logic [8:0] VEL_FULL = 9'h100;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef logic signed [5:0] ssg_db_type;
    typedef struct packed {
        ssg_db_type overall;
        ssg_db_type speed;
        ssg_db_type phase;
        ssg_db_type rough;
    } ssg_gain_set_type;
    typedef struct packed {
        logic oe;
        logic out;
    } ssg_pin_type;
    typedef enum logic [1:0] {SSG_ROUGH, SSG_PHASE, SSG_HOLD, SSG_AUTO} ssg_mode_type;
endpackage : ssg_pkg

/* File: rtl/ssg_pwm.sv */
// pwm generator for one signed servo error
`timescale 1ns/1ps
module ssg_pwm (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // error in, pulse out
    input wire logic signed [7:0] err,
    output logic pwm
);
    logic [7:0] ramp;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ramp <= 8'h00;
        end else begin
            ramp <= ramp + 8'h01;
        end
    end

    // offset binary, so zero error gives half duty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm <= 1'b0;
        end else begin
            pwm <= (ramp < (err ^ 8'h80));
        end
    end
endmodule : ssg_pwm

/* File: rtl/ssg_hold_div.sv */
// frame tick divider producing a hold strobe at one of two rates
`timescale 1ns/1ps
module ssg_hold_div #(
    parameter int SLOW_DIV = 32,
    parameter int FAST_DIV = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic tick,
    input wire logic fast_sel,
    input wire logic enable,
    // strobe
    output logic hold_pulse
);
    logic [5:0] count;
    logic [5:0] last;

    assign last = fast_sel ? 6'(FAST_DIV - 1) : 6'(SLOW_DIV - 1);

    // count frames; idle modes restart so the first strobe is a full period
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            count <= 6'h00;
            hold_pulse <= 1'b0;
        end else if (tick && count >= last) begin
            count <= 6'h00;
            hold_pulse <= 1'b1;
        end else begin
            count <= tick ? count + 6'h01 : count;
            hold_pulse <= 1'b0;
        end
    end
endmodule : ssg_hold_div

/* File: rtl/ssg_spindle_gain.sv */
// spindle servo gain control with axi4-lite register access
`timescale 1ns/1ps
module ssg_spindle_gain (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // servo side inputs
    input wire logic frame_clock,
    input wire logic phase_comparator_raw,
    input wire logic pll_locked,
    input wire logic signed [7:0] speed_error,
    input wire logic signed [7:0] phase_error,
    // motor driver side
    output ssg_pkg::ssg_pin_type phase_comparator_out_a,
    output ssg_pkg::ssg_pin_type phase_comparator_out_b,
    output ssg_pkg::ssg_pin_type speed_error_output,
    output ssg_pkg::ssg_pin_type phase_error_output,
    output ssg_pkg::ssg_gain_set_type gains,
    output ssg_pkg::ssg_mode_type servo_mode,
    output logic [9:0] target_speed_x32,
    output logic wide_range_allowed,
    output logic bottom_hold_pulse,
    output logic peak_hold_pulse
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] coef;
    logic [11:0] clv;
    logic [4:0] cfg;
    logic aw_full;
    logic w_full;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic do_write;
    logic next_aw_full;
    logic next_w_full;
    logic next_bvalid;
    logic next_rvalid;
    logic [7:0] waddr;
    logic [31:0] wword;
    logic [31:0] cmd_word;
    logic [31:0] rword;
    logic addr_hit;
    logic frame_s1;
    logic frame_s2;
    logic frame_s3;
    logic frame_tick;
    logic digital_spindle_enable;
    logic pwm_sel;
    ssg_pkg::ssg_mode_type next_mode;
    ssg_pkg::ssg_gain_set_type next_gains;
    ssg_pkg::ssg_pin_type next_pin;
    logic [8:0] vel_base;
    logic speed_pwm;
    logic phase_pwm;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic ssg_pkg::ssg_db_type step_gain(input logic [1:0] code);
        unique case (code)
            2'b00: return ssg_pkg::DB_M6;
            2'b01: return ssg_pkg::DB_0;
            2'b10: return ssg_pkg::DB_P6;
            2'b11: return ssg_pkg::DB_0;
        endcase
    endfunction : step_gain

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign do_write = (aw_full || aw_fire) && (w_full || w_fire) && !s_axi_bvalid;
    assign waddr = aw_fire ? s_axi_awaddr : awaddr_q;
    assign wword = w_fire ? s_axi_wdata : wdata_q;
    assign cmd_word = merge(32'h0000_0000, wword, w_fire ? s_axi_wstrb : wstrb_q);
    assign next_aw_full = do_write ? 1'b0 : (aw_full || aw_fire);
    assign next_w_full = do_write ? 1'b0 : (w_full || w_fire);
    assign next_bvalid = do_write ? 1'b1 : (s_axi_bvalid && s_axi_bready) ? 1'b0 : s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ssg_pkg::RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            if (aw_fire) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            s_axi_awready <= !next_aw_full && !next_bvalid;
            s_axi_wready <= !next_w_full && !next_bvalid;
            s_axi_bvalid <= next_bvalid;
            if (do_write) begin
                s_axi_bresp <= (waddr[7:2] <= ssg_pkg::ADDR_VEL[7:2]) ?
                               ssg_pkg::RESP_OKAY : ssg_pkg::RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------
    // command and configuration registers
    // ----------------------------------------
    // nibble selects command
    // the word is acted on only once address and data are both in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            coef <= ssg_pkg::COEF_RST;
            clv <= ssg_pkg::CLV_RST;
        end else if (do_write && waddr[7:2] == ssg_pkg::ADDR_CMD[7:2]) begin
            if (cmd_word[ssg_pkg::OP_LSB +: 4] == ssg_pkg::OP_COEF) begin
                coef <= cmd_word[ssg_pkg::COEF_LSB +: 8];
            end else if (cmd_word[ssg_pkg::OP_LSB +: 4] == ssg_pkg::OP_CLV) begin
                clv <= cmd_word[ssg_pkg::CLV_LSB +: 12];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= ssg_pkg::CFG_RST;
        end else if (do_write && waddr[7:2] == ssg_pkg::ADDR_CFG[7:2]) begin
            cfg <= 5'(merge({27'h0000000, cfg}, wword, w_fire ? s_axi_wstrb : wstrb_q));
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign next_rvalid = ar_fire ? 1'b1 : (s_axi_rvalid && s_axi_rready) ? 1'b0 : s_axi_rvalid;
    assign addr_hit = s_axi_araddr[7:2] <= ssg_pkg::ADDR_VEL[7:2];

    always_comb begin
        rword = 32'h0000_0000;
        unique case (s_axi_araddr[7:2])
            ssg_pkg::ADDR_COEF[7:2]: rword = {24'h000000, coef};
            ssg_pkg::ADDR_CLVC[7:2]: rword = {20'h00000, clv};
            ssg_pkg::ADDR_CFG[7:2]: rword = {27'h0000000, cfg};
            ssg_pkg::ADDR_STAT[7:2]: rword = {5'h00, servo_mode, wide_range_allowed, gains};
            ssg_pkg::ADDR_VEL[7:2]: rword = {22'h000000, target_speed_x32};
            default: rword = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ssg_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_fire) begin
                s_axi_rdata <= rword;
                s_axi_rresp <= addr_hit ? ssg_pkg::RESP_OKAY : ssg_pkg::RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------
    // gain decode
    // ----------------------------------------
    assign digital_spindle_enable = cfg[ssg_pkg::CFG_DIGITAL_SPINDLE_ENABLE];
    assign pwm_sel = clv[ssg_pkg::CLV_PWM];

    always_comb begin
        next_gains.phase = ssg_pkg::DB_0;
        next_gains.speed = ssg_pkg::DB_0;
        next_gains.overall = ssg_pkg::DB_0;
        next_gains.rough = ssg_pkg::DB_0;
        if (digital_spindle_enable) begin
            next_gains.phase = step_gain(coef[ssg_pkg::COEF_PHASE +: 2]);
            next_gains.speed = step_gain(coef[ssg_pkg::COEF_SPEED +: 2]);
            // reserved codes fall back to 0 dB
            unique case (coef[ssg_pkg::COEF_OVERALL +: 2])
                2'b00: next_gains.overall = ssg_pkg::DB_0;
                2'b01: next_gains.overall = ssg_pkg::DB_P6;
                2'b10: next_gains.overall = ssg_pkg::DB_P12;
                2'b11: next_gains.overall = ssg_pkg::DB_0;
            endcase
            unique case ({coef[ssg_pkg::COEF_SPEED +: 2], clv[ssg_pkg::CLV_ROUGH]})
                3'b000: next_gains.rough = ssg_pkg::DB_M12;
                3'b001, 3'b010: next_gains.rough = ssg_pkg::DB_M6;
                3'b011, 3'b100: next_gains.rough = ssg_pkg::DB_0;
                3'b101: next_gains.rough = ssg_pkg::DB_P6;
                3'b110, 3'b111: next_gains.rough = ssg_pkg::DB_0;
            endcase
        end else begin
            next_gains.rough = clv[ssg_pkg::CLV_ROUGH] ? ssg_pkg::DB_0 : ssg_pkg::DB_M12;
        end
    end

    // ----------------------------------------
    // servo mode and target velocity
    // ----------------------------------------
    // auto mode: rough while unlocked, phase once locked
    always_comb begin
        next_mode = ssg_pkg::ssg_mode_type'(cfg[ssg_pkg::CFG_MODE +: 2]);
        if (next_mode == ssg_pkg::SSG_AUTO) begin
            next_mode = pll_locked ? ssg_pkg::SSG_PHASE : ssg_pkg::SSG_ROUGH;
        end
    end

    // speed is (256 - code) / 32
    assign vel_base = ssg_pkg::VEL_FULL - {1'b0, clv[ssg_pkg::CLV_VEL +: 8]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gains <= '0;
            servo_mode <= ssg_pkg::SSG_ROUGH;
            target_speed_x32 <= 10'h000;
            wide_range_allowed <= 1'b0;
        end else begin
            gains <= next_gains;
            servo_mode <= next_mode;
            // double speed doubles
            // the caller must pair crystal and crystal select for these to hold
            target_speed_x32 <= cfg[ssg_pkg::CFG_DOUBLE_SPEED_SELECT] ? {vel_base, 1'b0} : {1'b0, vel_base};
            wide_range_allowed <= !pwm_sel;
        end
    end

    // ----------------------------------------
    // phase comparator pins
    // ----------------------------------------
    // pin field decode
    always_comb begin
        unique case (coef[ssg_pkg::COEF_PIN +: 2])
            2'b00: next_pin = '{oe: 1'b1, out: phase_comparator_raw};
            2'b01: next_pin = '{oe: 1'b0, out: 1'b0};
            2'b10: next_pin = '{oe: 1'b1, out: 1'b0};
            2'b11: next_pin = '{oe: 1'b1, out: 1'b1};
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_comparator_out_a <= '0;
            phase_comparator_out_b <= '0;
        end else begin
            phase_comparator_out_a <= next_pin;
            phase_comparator_out_b <= cfg[ssg_pkg::CFG_SECOND] ? next_pin : '0;
        end
    end

    // ----------------------------------------
    // error outputs
    // ----------------------------------------
    ssg_pwm u_speed_pwm (
        .aclk(aclk),
        .aresetn(aresetn),
        .err(speed_error),
        .pwm(speed_pwm)
    );

    ssg_pwm u_phase_pwm (
        .aclk(aclk),
        .aresetn(aresetn),
        .err(phase_error),
        .pwm(phase_pwm)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed_error_output <= '0;
            phase_error_output <= '0;
        end else if (pwm_sel) begin
            speed_error_output <= '{oe: 1'b1, out: speed_pwm};
            phase_error_output <= '{oe: 1'b1, out: phase_pwm};
        end else begin
            // ternary phase output
            // zero error floats the pin, sign picks the driven level
            speed_error_output <= '0;
            phase_error_output <= '{oe: (phase_error != 8'sh00), out: !phase_error[7]};
        end
    end

    // ----------------------------------------
    // frame clock and hold strobes
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_s1 <= 1'b0;
            frame_s2 <= 1'b0;
            frame_s3 <= 1'b0;
        end else begin
            frame_s1 <= frame_clock;
            frame_s2 <= frame_s1;
            frame_s3 <= frame_s2;
        end
    end

    assign frame_tick = frame_s2 && !frame_s3;

    ssg_hold_div #(
        .SLOW_DIV(ssg_pkg::BOTTOM_SLOW_DIV),
        .FAST_DIV(ssg_pkg::BOTTOM_FAST_DIV)
    ) u_bottom (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(frame_tick),
        .fast_sel(clv[ssg_pkg::CLV_TB]),
        .enable(servo_mode == ssg_pkg::SSG_ROUGH || servo_mode == ssg_pkg::SSG_HOLD),
        .hold_pulse(bottom_hold_pulse)
    );

    ssg_hold_div #(
        .SLOW_DIV(ssg_pkg::PEAK_SLOW_DIV),
        .FAST_DIV(ssg_pkg::PEAK_FAST_DIV)
    ) u_peak (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(frame_tick),
        .fast_sel(clv[ssg_pkg::CLV_TP]),
        .enable(servo_mode == ssg_pkg::SSG_ROUGH),
        .hold_pulse(peak_hold_pulse)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    gain_gate_a: assert property (!digital_spindle_enable ##1 !digital_spindle_enable |-> gains.phase == ssg_pkg::DB_0
        && gains.overall == ssg_pkg::DB_0) else $error("gains not gated by digital mode");
    rough_table_a: assert property (digital_spindle_enable && coef[5:4] == 2'b10 && clv[8] |=>
        gains.rough == ssg_pkg::DB_P6) else $error("rough gain table wrong");
    phase_step_a: assert property (digital_spindle_enable && coef[7:6] == 2'b00 |=>
        gains.phase == ssg_pkg::DB_M6) else $error("phase gain step wrong");
    overall_gain_a: assert property (digital_spindle_enable && coef[3:2] == 2'b10 |=>
        gains.overall == ssg_pkg::DB_P12) else $error("overall gain wrong");
    rough_off_a: assert property (!digital_spindle_enable |=>
        gains.rough == ($past(clv[8]) ? ssg_pkg::DB_0 : ssg_pkg::DB_M12))
        else $error("rough gain with digital off wrong");
    pin_float_a: assert property (coef[1:0] == 2'b01 |=>
        !phase_comparator_out_a.oe && !phase_comparator_out_b.oe) else $error("pins not floated");
    second_pin_a: assert property (!cfg[1] && coef[1:0] == 2'b11 |=>
        phase_comparator_out_a == 2'b11 && !phase_comparator_out_b.oe) else $error("pin b drove");
    pwm_mode_a: assert property (pwm_sel |=> !wide_range_allowed
        && speed_error_output.oe) else $error("pwm mode outputs wrong");
    ternary_out_a: assert property (!pwm_sel && phase_error == 8'sh00 |=>
        !phase_error_output.oe && !speed_error_output.oe) else $error("ternary output wrong");
    speed_code_a: assert property (clv[7:0] == 8'hE0 && cfg[2] |=>
        target_speed_x32 == 10'h040) else $error("double speed target wrong");
    cmd_apply_a: assert property (do_write && waddr == ssg_pkg::ADDR_CMD
        && cmd_word[27:24] == ssg_pkg::OP_COEF |=> coef == $past(cmd_word[23:16]))
        else $error("coefficient command not applied");
    reserved_code_a: assert property (digital_spindle_enable && coef[7:6] == 2'b11 |=>
        gains.phase == ssg_pkg::DB_0) else $error("reserved code gain undefined");
    peak_idle_a: assert property (servo_mode != ssg_pkg::SSG_ROUGH ##1
        servo_mode != ssg_pkg::SSG_ROUGH |=> !peak_hold_pulse) else $error("peak hold outside rough");
    auto_rough_a: assert property (cfg[4:3] == 2'b11 && !pll_locked |=>
        servo_mode == ssg_pkg::SSG_ROUGH) else $error("unlocked auto not rough");

    cmd_write_c: cover property (do_write && waddr == ssg_pkg::ADDR_CMD);
    bottom_pulse_c: cover property (bottom_hold_pulse);
    peak_pulse_c: cover property (peak_hold_pulse);
    read_done_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ssg_spindle_gain

/* File: test/ssg_far_side.sv */
// far-side model of the servo inputs
`timescale 1ns/1ps
module ssg_far_side (
    // clock
    input wire logic aclk,
    // servo side
    output logic frame_clock,
    output logic phase_comparator_raw,
    output logic pll_locked,
    output logic signed [7:0] speed_error,
    output logic signed [7:0] phase_error
);
    logic [7:0] cnt = 8'h00;
    always_ff @(posedge aclk) cnt <= cnt + 8'h01;
    assign frame_clock = cnt[2];
    assign phase_comparator_raw = cnt[0] ^ cnt[5];
    assign speed_error = $signed(cnt);
    assign phase_error = $signed(~cnt);
    // crystal matched; lock comes and goes for auto mode
    assign pll_locked = cnt[7];
endmodule : ssg_far_side

/* File: test/ssg_spindle_gain_tb.sv */
// self-checking bench for the spindle servo gain block
`timescale 1ns/1ps
module ssg_spindle_gain_tb;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0, raw_q, pl_q;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bvalid;
    logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid, wide_range_allowed;
    logic frame_clock, phase_comparator_raw, pll_locked, bottom_hold_pulse, peak_hold_pulse;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, c;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, pa;
    logic [11:0] v;
    logic [9:0] target_speed_x32;
    logic [4:0] cf;
    logic [23:0] e;
    logic signed [7:0] speed_error, phase_error, pe_q;
    ssg_pkg::ssg_pin_type phase_comparator_out_a, phase_comparator_out_b;
    ssg_pkg::ssg_pin_type speed_error_output, phase_error_output;
    ssg_pkg::ssg_gain_set_type gains;
    ssg_pkg::ssg_mode_type servo_mode;
    int n_errors = 0, comparisons = 0, seed = 48, n;
    logic [5:0] gt [4] = '{6'h3A, 6'h00, 6'h06, 6'h00};
    logic [5:0] ot [4] = '{6'h00, 6'h06, 6'h0C, 6'h00};
    logic [5:0] rt [8] = '{6'h34, 6'h3A, 6'h3A, 6'h00, 6'h00, 6'h06, 6'h00, 6'h00};
    ssg_spindle_gain uut (.*);
    ssg_far_side far_side (.*);
    initial forever #12.5 aclk = ~aclk;
    always @(posedge aclk) {raw_q, pl_q, pe_q} <= {phase_comparator_raw, pll_locked, phase_error};
    task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", s, exp, got);
        end
    endtask : chk
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] dw);
        bit done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= dw;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            done = s_axi_bvalid | s_axi_rvalid;
        end
        {s_axi_bready, s_axi_rready} <= 2'h0;
        {d, r} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
    endtask : bus
    function automatic logic [1:0] pv(input ssg_pkg::ssg_pin_type p);
        return {p.oe, p.oe & p.out};
    endfunction : pv
    task automatic finish_test();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        bus(1, ssg_pkg::ADDR_CMD, 32'h0EFF0000);
        chk("bresp", r, ssg_pkg::RESP_OKAY);
        bus(1, 8'h18, 32'hFFFF_FFFF);
        chk("bad write", r, ssg_pkg::RESP_SLVERR);
        bus(0, ssg_pkg::ADDR_COEF, 32'h0);
        chk("coef", d, 32'h50);
        bus(0, 8'h18, 32'h0);
        chk("unmapped", {r, d[29:0]}, {ssg_pkg::RESP_SLVERR, 30'h0});
        for (int i = 0; i < 40; i++) begin
            c = i < 2 ? {8{i[0]}} : 8'($random(seed));
            v = 12'($random(seed));
            cf = 5'($random(seed));
            bus(1, ssg_pkg::ADDR_CFG, {27'h0, cf});
            bus(1, ssg_pkg::ADDR_CMD, {4'h0, ssg_pkg::OP_COEF, c, 16'h0});
            bus(1, ssg_pkg::ADDR_CMD, {4'h0, ssg_pkg::OP_CLV, v, 12'h0});
            repeat (2) @(posedge aclk);
            #1;
            e = cf[0] ? {ot[c[3:2]], gt[c[5:4]], gt[c[7:6]], rt[{c[5:4], v[8]}]}
                : {18'h0, v[8] ? 6'h00 : 6'h34};
            pa = c[1:0] == 2'h0 ? {1'b1, raw_q} : c[1:0] == 2'h1 ? 2'h0 : {1'b1, c[0]};
            chk("gains", gains, e);
            chk("wide", wide_range_allowed, !v[11]);
            chk("pwm", speed_error_output.oe, v[11]);
            chk("speed", target_speed_x32, (32'h100 - v[7:0]) << cf[2]);
            chk("pin a", pv(phase_comparator_out_a), pa);
            chk("pin b", pv(phase_comparator_out_b), cf[1] ? pa : 2'h0);
            chk("mode", servo_mode, cf[4:3] == 2'h3 ? {1'b0, pl_q} : cf[4:3]);
            chk("phase oe", phase_error_output.oe, v[11] || pe_q != 8'sh00);
            if (!v[11] && pe_q != 8'sh00) chk("phase lvl", phase_error_output.out, !pe_q[7]);
        end
        bus(1, ssg_pkg::ADDR_CFG, 32'h0);
        for (int k = 0; k < 4; k++) begin
            bus(1, ssg_pkg::ADDR_CMD, {4'h0, ssg_pkg::OP_CLV, 1'b0, k[1:0], 21'h0E0000});
            n = 0;
            repeat (2) @(posedge bottom_hold_pulse);
            @(negedge bottom_hold_pulse);
            do @(negedge aclk) n += int'(peak_hold_pulse);
            while (!bottom_hold_pulse);
            chk("peaks", n, (k[1] ? 16 : 32) / (k[0] ? 2 : 4));
        end
        finish_test();
    end
    initial begin
        #500000;
        n_errors++;
        finish_test();
    end
endmodule : ssg_spindle_gain_tb
